// ==== logic/obs_pkg.sv ====
// shared constants for the out-of-band and beacon sequencer
package obs_pkg;
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_CONFIG    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
    // control word fields
    localparam int          CTRL_LAUNCH    = 0;
    localparam int          CTRL_KIND      = 1;
    localparam int          CTRL_IDLE      = 2;
    localparam int          CTRL_PWR_LO    = 3;
    localparam int          CTRL_FMT_SATA  = 5;
    localparam logic [1:0]  PWR_P0         = 2'h0;
    localparam logic [1:0]  PWR_P2         = 2'h3;
    localparam logic        KIND_RESET     = 1'h0;
    localparam logic        KIND_WAKE      = 1'h1;
    // config word fields
    localparam int          CFG_BURST_LO   = 0;
    localparam int          CFG_DIV_LO     = 4;
    localparam logic [3:0]  BURST_RESET    = 4'h6;
    localparam logic [2:0]  DIV_GEN2       = 3'h1;
    localparam logic [2:0]  DIV_GEN1       = 3'h2;
    localparam logic [2:0]  DIV_RESET      = 3'h2;
    // interrupt bits
    localparam int          IRQ_DONE       = 0;
    localparam int          IRQ_RX_WAKE    = 1;
    localparam int          IRQ_RX_RESET   = 2;
    localparam int          IRQ_REFUSED    = 3;
    localparam int          IRQ_BEACON     = 4;
    localparam int          IRQ_W          = 5;
    // sequencer states
    typedef enum logic [3:0] {
        OBS_IDLE  = 4'b0001,
        OBS_BURST = 4'b0010,
        OBS_GAP   = 4'b0100,
        OBS_DONE  = 4'b1000
    } obs_state_t;
    localparam int          TIMER_W        = 16;
endpackage

// ==== logic/obs_interval_timer.sv ====
// down-counting interval timer for burst and gap lengths
`timescale 1ns/1ps
`default_nettype none
module obs_interval_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_i,      // system clock
    input  wire logic         rst_i,      // sync reset, high
    input  wire logic         load_i,     // start a new interval
    input  wire logic [W-1:0] length_i,   // interval length in cycles
    output logic              expire_o    // high in last cycle of interval
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_expire;
    logic         expire;

    initial begin
        if (W < 2) $error("timer width too small");
    end

    always_comb begin
        next_count  = count;
        if (load_i) begin
            next_count = length_i;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
        next_expire = (next_count == W'(1));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count  <= '0;
            expire <= 1'b0;
        end else begin
            count  <= next_count;
            expire <= next_expire;
        end
    end

    assign expire_o = expire;
endmodule
`default_nettype wire

// ==== logic/obs_sequencer.sv ====
// out-of-band burst and beacon sequencer with wishbone registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - beacons are produced only while power state is P2.
// - in P2, beacon drive starts when idle control is deasserted.
// - with idle held high in P0, a SATA divider and no sequence running, a one-cycle launch sends exactly one COM sequence.
// - sequence kind is taken from the kind select at launch.
// - each sequence emits the configured number of bursts.
// - divider changes at run time have no effect on timing; the divider only gates a launch.
// - in SATA format, completion drives status bit zero high for exactly one cycle.
// - kind select 0 means reset/init, 1 means wake.
// - burst count is a four-bit binary value.
// - SATA format: bit0 launch done, bit1 wake seen, bit2 reset seen.
module obs_sequencer
    import obs_pkg::*;
#(
    parameter int BURST_NS     = 107,
    parameter int GAP_RESET_NS = 320,
    parameter int GAP_WAKE_NS  = 107
) (
    input  wire logic                      clk_i,          // 20 MHz clock
    input  wire logic                      rst_i,          // sync reset, high
    input  wire logic                      wb_cyc_i,       // wishbone cycle
    input  wire logic                      wb_stb_i,       // wishbone strobe
    input  wire logic                      wb_we_i,        // wishbone write
    input  wire logic [obs_pkg::ADDR_W-1:0] wb_adr_i,      // byte address
    input  wire logic [3:0]                wb_sel_i,       // byte enables
    input  wire logic [obs_pkg::DATA_W-1:0] wb_dat_i,      // write data
    output logic [obs_pkg::DATA_W-1:0]     wb_dat_o,       // read data
    output logic                           wb_ack_o,       // wishbone ack
    input  wire logic                      rx_wake_seen_i, // receiver saw wake, pulse
    input  wire logic                      rx_reset_seen_i,// receiver saw reset/init, pulse
    output logic                           tx_burst_o,     // burst on tx pair
    output logic                           tx_elec_idle_o, // tx pair in electrical idle
    output logic                           beacon_o,       // beacon on tx pair
    output logic [2:0]                     rx_status_o,    // status bus
    output logic                           irq_o           // level interrupt
);
    import obs_pkg::*;

    // least times round up to whole cycles
    localparam int BURST_CYC     = (BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_RESET_CYC = (GAP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_WAKE_CYC  = (GAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    initial begin
        if (BURST_CYC < 1 || GAP_RESET_CYC < 1 || GAP_WAKE_CYC < 1) $error("interval below one cycle");
        if (GAP_RESET_CYC >= (1 << TIMER_W)) $error("interval too long for timer");
    end

    // register state
    logic             kind_sel;
    logic             idle_ctrl;
    logic [1:0]       pwr_state;
    logic             fmt_sata;
    logic [3:0]       burst_setting;
    logic [2:0]       line_div;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             ack;
    logic [31:0]      rdata;
    logic             next_kind_sel;
    logic             next_idle_ctrl;
    logic [1:0]       next_pwr_state;
    logic             next_fmt_sata;
    logic [3:0]       next_burst_setting;
    logic [2:0]       next_line_div;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic             next_ack;
    logic [31:0]      next_rdata;
    logic             launch_req;

    // sequencer state
    obs_state_t       state;
    obs_state_t       next_state;
    logic             seq_kind;
    logic             next_seq_kind;
    logic [3:0]       bursts_left;
    logic [3:0]       next_bursts_left;
    logic             timer_load;
    logic [TIMER_W-1:0] timer_len;
    logic             timer_expire;
    logic             busy;
    logic             launch_ok;
    logic             launch_bad;
    logic             done_evt;

    // output flops
    logic             burst_q;
    logic             idle_q;
    logic             beacon_q;
    logic [2:0]       status_q;
    logic             irq_q;
    logic             next_burst_q;
    logic             next_idle_q;
    logic             next_beacon_q;
    logic [2:0]       next_status_q;
    logic             next_irq_q;

    logic wr_hit;
    logic req;
    assign req    = wb_cyc_i && wb_stb_i;
    // write lands on the edge where the master sees ack
    assign wr_hit = req && ack && wb_we_i;

    // bus slave and register file
    always_comb begin
        next_kind_sel      = kind_sel;
        next_idle_ctrl     = idle_ctrl;
        next_pwr_state     = pwr_state;
        next_fmt_sata      = fmt_sata;
        next_burst_setting = burst_setting;
        next_line_div      = line_div;
        next_irq_mask      = irq_mask;
        next_irq_stat      = irq_stat;
        next_ack           = req && !ack;
        next_rdata         = rdata;
        launch_req         = 1'b0;
        if (wr_hit && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    launch_req     = wb_dat_i[CTRL_LAUNCH];
                    next_kind_sel  = wb_dat_i[CTRL_KIND];
                    next_idle_ctrl = wb_dat_i[CTRL_IDLE];
                    next_pwr_state = wb_dat_i[CTRL_PWR_LO +: 2];
                    next_fmt_sata  = wb_dat_i[CTRL_FMT_SATA];
                end
                ADDR_CONFIG: begin
                    next_burst_setting = wb_dat_i[CFG_BURST_LO +: 4];
                    next_line_div      = wb_dat_i[CFG_DIV_LO +: 3];
                end
                ADDR_IRQ_STAT: begin
                    next_irq_stat = irq_stat & ~wb_dat_i[IRQ_W-1:0];
                end
                ADDR_IRQ_MASK: begin
                    next_irq_mask = wb_dat_i[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        next_irq_stat[IRQ_DONE]     = next_irq_stat[IRQ_DONE] | done_evt;
        next_irq_stat[IRQ_RX_WAKE]  = next_irq_stat[IRQ_RX_WAKE] | rx_wake_seen_i;
        next_irq_stat[IRQ_RX_RESET] = next_irq_stat[IRQ_RX_RESET] | rx_reset_seen_i;
        next_irq_stat[IRQ_REFUSED]  = next_irq_stat[IRQ_REFUSED] | launch_bad;
        next_irq_stat[IRQ_BEACON]   = next_irq_stat[IRQ_BEACON] | (next_beacon_q && !beacon_q);
        if (req && !ack) begin
            case (wb_adr_i)
                ADDR_CTRL:     next_rdata = {26'h0, fmt_sata, pwr_state, idle_ctrl, kind_sel, 1'b0};
                ADDR_CONFIG:   next_rdata = {25'h0, line_div, burst_setting};
                ADDR_STATUS:   next_rdata = {27'h0, beacon_q, busy, status_q};
                ADDR_IRQ_STAT: next_rdata = {27'h0, irq_stat};
                ADDR_IRQ_MASK: next_rdata = {27'h0, irq_mask};
                default:       next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kind_sel      <= KIND_RESET;
            idle_ctrl     <= 1'b1;
            pwr_state     <= PWR_P0;
            fmt_sata      <= 1'b1;
            burst_setting <= BURST_RESET;
            line_div      <= DIV_RESET;
            irq_stat      <= '0;
            irq_mask      <= '0;
            ack           <= 1'b0;
            rdata         <= 32'h0;
        end else begin
            kind_sel      <= next_kind_sel;
            idle_ctrl     <= next_idle_ctrl;
            pwr_state     <= next_pwr_state;
            fmt_sata      <= next_fmt_sata;
            burst_setting <= next_burst_setting;
            line_div      <= next_line_div;
            irq_stat      <= next_irq_stat;
            irq_mask      <= next_irq_mask;
            ack           <= next_ack;
            rdata         <= next_rdata;
        end
    end

    // a launch is taken only with idle held high, P0 and a SATA divider
    assign busy       = (state != OBS_IDLE);
    assign launch_ok  = launch_req && !busy && next_idle_ctrl && (next_pwr_state == PWR_P0)
                        && (line_div == DIV_GEN1 || line_div == DIV_GEN2);
    assign launch_bad = launch_req && !launch_ok;

    // divider is only checked at launch, so a run-time rate change never alters timing;
    // both legal rates keep the same absolute burst timing
    always_comb begin
        next_state       = state;
        next_seq_kind    = seq_kind;
        next_bursts_left = bursts_left;
        timer_load       = 1'b0;
        timer_len        = TIMER_W'(BURST_CYC);
        done_evt         = 1'b0;
        case (state)
            OBS_IDLE: begin
                if (launch_ok) begin
                    next_seq_kind    = next_kind_sel;
                    next_bursts_left = burst_setting;
                    if (burst_setting == 4'h0) begin
                        next_state = OBS_DONE;
                    end else begin
                        next_state = OBS_BURST;
                        timer_load = 1'b1;
                    end
                end
            end
            OBS_BURST: begin
                if (timer_expire) begin
                    next_state       = OBS_GAP;
                    timer_load       = 1'b1;
                    next_bursts_left = bursts_left - 4'h1;
                    timer_len        = (seq_kind == KIND_WAKE) ? TIMER_W'(GAP_WAKE_CYC)
                                                               : TIMER_W'(GAP_RESET_CYC);
                end
            end
            OBS_GAP: begin
                if (timer_expire) begin
                    if (bursts_left == 4'h0) begin
                        next_state = OBS_DONE;
                    end else begin
                        next_state = OBS_BURST;
                        timer_load = 1'b1;
                    end
                end
            end
            OBS_DONE: begin
                done_evt   = 1'b1;
                next_state = OBS_IDLE;
            end
            default: begin
                next_state = OBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state       <= OBS_IDLE;
            seq_kind    <= KIND_RESET;
            bursts_left <= 4'h0;
        end else begin
            state       <= next_state;
            seq_kind    <= next_seq_kind;
            bursts_left <= next_bursts_left;
        end
    end

    obs_interval_timer #(
        .W        (TIMER_W)
    ) u_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (timer_load),
        .length_i (timer_len),
        .expire_o (timer_expire)
    );

    // line and status outputs, all registered
    always_comb begin
        next_burst_q  = (next_state == OBS_BURST);
        next_beacon_q = (pwr_state == PWR_P2) && !idle_ctrl;
        next_idle_q   = idle_ctrl && !next_burst_q;
        next_status_q = 3'h0;
        if (fmt_sata) begin
            next_status_q = {rx_reset_seen_i, rx_wake_seen_i, done_evt};
        end
        next_irq_q    = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            burst_q  <= 1'b0;
            idle_q   <= 1'b1;
            beacon_q <= 1'b0;
            status_q <= 3'h0;
            irq_q    <= 1'b0;
        end else begin
            burst_q  <= next_burst_q;
            idle_q   <= next_idle_q;
            beacon_q <= next_beacon_q;
            status_q <= next_status_q;
            irq_q    <= next_irq_q;
        end
    end

    assign wb_dat_o       = rdata;
    assign wb_ack_o       = ack;
    assign tx_burst_o     = burst_q;
    assign tx_elec_idle_o = idle_q;
    assign beacon_o       = beacon_q;
    assign rx_status_o    = status_q;
    assign irq_o          = irq_q;
endmodule
`default_nettype wire

// ==== sim/obs_sequencer_props.sv ====
// concurrent checks on the sequencer ports, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module obs_sequencer_props
    import obs_pkg::*;
(
    input  wire logic       clk_i,           // clock
    input  wire logic       rst_i,           // sync reset
    input  wire logic       wb_cyc_i,        // bus cycle
    input  wire logic       wb_stb_i,        // bus strobe
    input  wire logic       wb_ack_o,        // bus ack
    input  wire logic       rx_wake_seen_i,  // wake seen pulse
    input  wire logic       rx_reset_seen_i, // reset seen pulse
    input  wire logic       tx_burst_o,      // burst on pair
    input  wire logic       tx_elec_idle_o,  // pair idle
    input  wire logic       beacon_o,        // beacon on pair
    input  wire logic [2:0] rx_status_o      // status bus
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // burst length 3 cycles, one cycle of slack either way
    sequence s_burst;
        tx_burst_o ##1 tx_burst_o ##[1:3] !tx_burst_o;
    endsequence
    sequence s_gap;
        !tx_burst_o [*2];
    endsequence
    beacon_excl_a: assert property (beacon_o |-> !tx_burst_o)
        else $error("beacon and burst together");
    burst_drive_a: assert property (tx_burst_o |-> !tx_elec_idle_o)
        else $error("idle shown during burst");
    burst_len_a: assert property ($rose(tx_burst_o) |-> s_burst)
        else $error("burst length wrong");
    gap_min_a: assert property ($fell(tx_burst_o) |-> s_gap)
        else $error("gap too short");
    done_bound_a: assert property ($fell(tx_burst_o) |-> ##[1:12] (tx_burst_o || rx_status_o[0]))
        else $error("no completion after last burst");
    done_pulse_a: assert property (rx_status_o[0] |=> !rx_status_o[0])
        else $error("completion flag longer than one cycle");
    wake_copy_a: assert property (rx_wake_seen_i |=> rx_status_o[1])
        else $error("wake seen not reported");
    reset_copy_a: assert property (rx_reset_seen_i |=> rx_status_o[2])
        else $error("reset seen not reported");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule
bind obs_sequencer obs_sequencer_props i_obs_sequencer_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_wake_seen_i(rx_wake_seen_i), .rx_reset_seen_i(rx_reset_seen_i),
    .tx_burst_o(tx_burst_o), .tx_elec_idle_o(tx_elec_idle_o), .beacon_o(beacon_o), .rx_status_o(rx_status_o));
`default_nettype wire

// ==== sim/obs_link_partner.sv ====
// far-end model: counts bursts, classes the gap, answers with a seen pulse
`timescale 1ns/1ps
`default_nettype none
module obs_link_partner (
    input  wire logic       clk_i,        // clock
    input  wire logic       rst_i,        // sync reset
    input  wire logic       burst_i,      // burst on pair
    output logic            wake_seen_o,  // wake heard, pulse
    output logic            reset_seen_o, // reset heard, pulse
    output logic [4:0]      bursts_o,     // bursts in last sequence
    output logic [4:0]      gap_o         // first gap length seen
);
    logic       prev;
    logic       gap_run;
    logic [4:0] quiet;
    always_ff @(posedge clk_i) begin
        wake_seen_o  <= 1'b0;
        reset_seen_o <= 1'b0;
        if (rst_i) begin
            prev     <= 1'b0;
            gap_run  <= 1'b0;
            quiet    <= 5'h1F;
            bursts_o <= 5'h00;
            gap_o    <= 5'h00;
        end else begin
            prev  <= burst_i;
            quiet <= burst_i ? 5'h00 : (quiet == 5'h1F ? quiet : quiet + 5'h01);
            if (burst_i && !prev) begin
                // a long quiet spell marks the start of a new sequence
                bursts_o <= (quiet >= 5'h0C) ? 5'h01 : bursts_o + 5'h01;
                gap_run  <= 1'b0;
                if (quiet >= 5'h0C)
                    gap_o <= 5'h00;
            end
            if (!burst_i && prev && bursts_o == 5'h01)
                gap_run <= 1'b1;
            if (gap_run && !burst_i)
                gap_o <= gap_o + 5'h01;
            // answer once the sequence has gone quiet
            if (quiet == 5'h0B && bursts_o != 5'h00) begin
                wake_seen_o  <= (gap_o < 5'h05);
                reset_seen_o <= (gap_o >= 5'h05);
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench: register access, COM sequences, refusals, beacons, irq
`timescale 1ns/1ps
`default_nettype none
module tb;
    import obs_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic        ack, burst, idle, beacon, irq, wake, rst_seen;
    logic [2:0]  status;
    logic [4:0]  bursts, gap;
    int          fails = 0, total_checks = 0;
    obs_sequencer i_obs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_wake_seen_i(wake),
        .rx_reset_seen_i(rst_seen), .tx_burst_o(burst), .tx_elec_idle_o(idle), .beacon_o(beacon),
        .rx_status_o(status), .irq_o(irq));
    obs_link_partner i_obs_link_partner (.clk_i(clk_i), .rst_i(rst_i), .burst_i(burst), .wake_seen_o(wake),
        .reset_seen_o(rst_seen), .bursts_o(bursts), .gap_o(gap));
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end
    task automatic give_verdict();
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle; ack sampled at the edge, released right there
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (ack !== 1'b1) begin fails++; give_verdict(); end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb_cycle(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic run_com(input logic kind, input logic [2:0] div);
        int n;
        n = 0;
        wb_cycle(1'b1, ADDR_CONFIG, {25'h0, div, 4'h2});
        wb_cycle(1'b1, ADDR_CTRL, 32'h25 | (32'(kind) << 1));
        do begin
            @(posedge clk_i);
            n++;
        end while (status[0] !== 1'b1 && n < 200);
        if (status[0] !== 1'b1) begin fails++; give_verdict(); end
        @(posedge clk_i);
        chk("done_width", 32'h0, 32'(status[0]));
        repeat (20) @(posedge clk_i);
        chk("burst_count", 32'h2, 32'(bursts));
        chk("gap_class", 32'(!kind), 32'(gap >= 5'h05));
        chk("irq_level", 32'h1, 32'(irq));
        rd_chk("irq_stat", ADDR_IRQ_STAT, kind ? 32'h3 : 32'h5);
        wb_cycle(1'b1, ADDR_IRQ_STAT, 32'h1F);
        repeat (2) @(posedge clk_i);
        chk("irq_clear", 32'h0, 32'(irq));
    endtask
    task automatic refuse(input logic [31:0] cfg, input logic [31:0] ctl);
        wb_cycle(1'b1, ADDR_CONFIG, cfg);
        wb_cycle(1'b1, ADDR_CTRL, ctl);
        repeat (4) @(posedge clk_i);
        chk("refused_burst", 32'h0, 32'(burst));
        rd_chk("refused_irq", ADDR_IRQ_STAT, 32'h8);
        wb_cycle(1'b1, ADDR_IRQ_STAT, 32'h1F);
    endtask
    task automatic beacon_step(input logic [31:0] ctl, input logic e);
        wb_cycle(1'b1, ADDR_CTRL, ctl);
        repeat (2) @(posedge clk_i);
        chk("beacon", 32'(e), 32'(beacon));
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl_rst", ADDR_CTRL, 32'h24);
        rd_chk("config_rst", ADDR_CONFIG, 32'h26);
        rd_chk("status_rst", ADDR_STATUS, 32'h0);
        rd_chk("irq_stat_rst", ADDR_IRQ_STAT, 32'h0);
        rd_chk("irq_mask_rst", ADDR_IRQ_MASK, 32'h0);
        wb_cycle(1'b1, 8'h20, 32'hFF);
        rd_chk("unmapped", 8'h20, 32'h0);
        wb_cycle(1'b1, ADDR_IRQ_MASK, 32'h07);
        // both kinds at both rates; timing must not depend on the divider
        for (int k = 0; k < 4; k++)
            run_com(k[0], k[1] ? DIV_GEN2 : DIV_GEN1);
        // zero bursts: completion with nothing on the pair
        wb_cycle(1'b1, ADDR_CONFIG, 32'h20);
        wb_cycle(1'b1, ADDR_CTRL, 32'h25);
        repeat (4) @(posedge clk_i);
        chk("zero_burst", 32'h0, 32'(burst));
        rd_chk("zero_burst_irq", ADDR_IRQ_STAT, 32'h1);
        wb_cycle(1'b1, ADDR_IRQ_STAT, 32'h1F);
        refuse(32'h22, 32'h21);
        refuse(32'h42, 32'h25);
        refuse(32'h22, 32'h3D);
        wb_cycle(1'b1, ADDR_IRQ_MASK, 32'h10);
        beacon_step(32'h38, 1'b1);
        chk("beacon_irq", 32'h1, 32'(irq));
        beacon_step(32'h3C, 1'b0);
        beacon_step(32'h20, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
